// ### sfsp_pkg.sv
// shared constants for the serial flash port
package sfsp_pkg;
   // command codes (plain defaults, change to suit the command set)
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_READ_ID = 8'h90;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   // identification codes, values are arbitrary
   localparam logic [7:0] MAKER_ID = 8'hA5;
   localparam logic [7:0] DEVICE_ID = 8'h5A;
   // status field positions
   localparam int ST_BUSY = 0;
   localparam int ST_WRITE_ENABLE = 1;
   localparam int ST_LEVEL_LO = 2;
   localparam int ST_LEVEL_HI = 3;
   localparam int ST_AAI = 6;
   localparam int ST_LOCK = 7;
   // power-up values of the protection bits
   localparam logic RST_LOCK = 1'b0;
   localparam logic RST_LEVEL = 1'b1;
   // array organisation: 16 address bits, 4 KByte sectors, 32 KByte blocks
   localparam int ADDR_W = 16;
   localparam int SECTOR_LSB = 12;
   localparam int BLOCK_LSB = 15;
   localparam logic [1:0] LAST_ADDR_BYTE = 2'h2;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // number of pins that cross into the clock domain
   localparam int PIN_CNT = 5;
   // protocol phase of a frame
   typedef enum logic [1:0] {ph_opcode, ph_addr, ph_data, ph_ignore} sfsp_phase_e;
endpackage

// ### sfsp_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser for a group of pins
module sfsp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] pin_sync_o
);
   logic [WIDTH-1:0] stage1; // metastable stage, read only by stage two

   // reset to ones: select and pause read inactive, so no false pause after reset
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage1 <= '1;
         pin_sync_o <= '1;
      end else begin
         stage1 <= pin_i;
         pin_sync_o <= stage1;
      end
   end
endmodule
`default_nettype wire

// ### sfsp_port.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - input bits taken on serial clock rise
// - output bits shifted on serial clock fall
// - idle clock low or high both work
// - pause entered only with clock low, selected
// - pause left when input high, clock low
// - paused: output released, clock and input ignored
// - pause freezes counting, resumes same point
// - deselect while paused resets interface, pause stays
// - status write refused when locked, protect low
// - id locations return maker, device codes
// - array split into 4K sectors, 32K blocks
// - status shows busy, write enable, protection
// - status bit zero reports internal busy
// - lock freezes protect bits while protect is low; lock clears at power-up
// - levels power up set; chip erase needs zero
// - all bytes move most significant bit first
module sfsp_port (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic sck_i, // serial clock pin
   input wire logic si_i, // serial data in
   input wire logic cs_n_i, // chip select, active low
   input wire logic hold_n_i, // pause, active low
   input wire logic wp_n_i, // write protect, active low
   input wire logic busy_i, // internal erase/program running
   input wire logic write_enable_latch_i, // write enable state from the engine
   input wire logic aai_i, // auto-increment programming mode
   input wire logic [7:0] mem_rdata_i, // array data at array_addr_o
   output logic so_o, // serial data out
   output logic so_oe_o, // high while driving so_o
   output logic [7:0] status_o, // status byte
   output logic [7:0] opcode_o, // last opcode received
   output logic opcode_valid_o, // one-cycle pulse per opcode
   output logic [15:0] array_addr_o, // byte address into the array
   output logic [3:0] sector_o, // 4 KByte sector of array_addr_o
   output logic block_o, // 32 KByte block of array_addr_o
   output logic chip_erase_allowed_o // both protect levels clear
);
   logic [sfsp_pkg::PIN_CNT-1:0] pins_s; // synchronised pins
   logic sck_s, si_s, cs_n_s, hold_n_s, wp_n_s;
   logic sck_prev; // last sampled clock level
   logic hold_active; // device is paused
   logic rise_ev, fall_ev; // qualified serial clock edges
   logic [2:0] bit_cnt; // bit within the current byte
   logic [6:0] shift_in; // bits gathered so far
   logic [7:0] rx_byte; // byte completed by this edge
   logic byte_done; // last bit of a byte taken
   sfsp_pkg::sfsp_phase_e phase;
   logic [1:0] addr_cnt; // address bytes taken
   logic [7:0] out_reg; // outgoing byte, msb first
   logic out_active; // response phase reached
   logic load_pending; // refill out_reg next cycle
   logic lock, level_hi, level_lo; // protection bits
   logic status_wr; // status write attempt this cycle
   logic status_wr_ok;

   sfsp_sync #(.WIDTH(sfsp_pkg::PIN_CNT)) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .pin_i({sck_i, si_i, cs_n_i, hold_n_i, wp_n_i}),
      .pin_sync_o(pins_s)
   );
   assign {sck_s, si_s, cs_n_s, hold_n_s, wp_n_s} = pins_s;

   // edges seen only while selected and not paused; idle level does not matter
   assign rise_ev = sck_s && !sck_prev && !cs_n_s && !hold_active;
   assign fall_ev = !sck_s && sck_prev && !cs_n_s && !hold_active;
   assign byte_done = rise_ev && (bit_cnt == sfsp_pkg::LAST_BIT);
   assign rx_byte = {shift_in, si_s};

   // clock level history, kept even while paused so no false edge on resume
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sck_prev <= 1'b1; // matches the synchroniser's idle-high reset level
      end else begin
         sck_prev <= sck_s;
      end
   end

   // pause tracking; a deferred change simply waits for the clock to be low
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_active <= 1'b0;
      end else if (!hold_active) begin
         if (!cs_n_s && !hold_n_s && !sck_s) begin
            hold_active <= 1'b1;
         end
      end else if (hold_n_s && !sck_s) begin
         hold_active <= 1'b0;
      end
   end

   // bit gathering; deselect clears it even during a pause
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_cnt <= 3'h0;
         shift_in <= 7'h00;
      end else if (cs_n_s) begin
         bit_cnt <= 3'h0;
         shift_in <= 7'h00;
      end else if (rise_ev) begin
         bit_cnt <= bit_cnt + 3'h1;
         shift_in <= rx_byte[6:0];
      end
   end

   // command decode per completed byte
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase <= sfsp_pkg::ph_opcode;
         opcode_o <= 8'h00;
         addr_cnt <= 2'h0;
         array_addr_o <= 16'h0000;
         out_active <= 1'b0;
         load_pending <= 1'b0;
      end else if (cs_n_s) begin
         phase <= sfsp_pkg::ph_opcode;
         addr_cnt <= 2'h0;
         out_active <= 1'b0;
         load_pending <= 1'b0;
      end else begin
         load_pending <= 1'b0;
         if (byte_done) begin
            unique case (phase)
               sfsp_pkg::ph_opcode: begin
                  opcode_o <= rx_byte;
                  if (rx_byte == sfsp_pkg::OP_STATUS_READ) begin
                     phase <= sfsp_pkg::ph_data;
                     out_active <= 1'b1;
                     load_pending <= 1'b1;
                  end else if (rx_byte == sfsp_pkg::OP_STATUS_WRITE) begin
                     phase <= sfsp_pkg::ph_data;
                  end else if (rx_byte == sfsp_pkg::OP_READ || rx_byte == sfsp_pkg::OP_READ_ID) begin
                     phase <= sfsp_pkg::ph_addr;
                  end else begin
                     phase <= sfsp_pkg::ph_ignore; // unknown code: stay silent to frame end
                  end
               end
               sfsp_pkg::ph_addr: begin
                  // only the low 16 bits address this array
                  array_addr_o <= {array_addr_o[7:0], rx_byte};
                  addr_cnt <= addr_cnt + 2'h1;
                  if (addr_cnt == sfsp_pkg::LAST_ADDR_BYTE) begin
                     phase <= sfsp_pkg::ph_data;
                     out_active <= 1'b1;
                     load_pending <= 1'b1;
                  end
               end
               sfsp_pkg::ph_data: begin
                  if (opcode_o == sfsp_pkg::OP_STATUS_WRITE) begin
                     phase <= sfsp_pkg::ph_ignore; // one status byte per frame
                  end else begin
                     load_pending <= 1'b1;
                     if (opcode_o != sfsp_pkg::OP_STATUS_READ) begin
                        array_addr_o <= array_addr_o + 16'h0001;
                     end
                  end
               end
               sfsp_pkg::ph_ignore: begin
                  phase <= sfsp_pkg::ph_ignore;
               end
            endcase
         end
      end
   end

   assign opcode_valid_o = byte_done && (phase == sfsp_pkg::ph_opcode);
   assign sector_o = array_addr_o[sfsp_pkg::SECTOR_LSB +: 4];
   assign block_o = array_addr_o[sfsp_pkg::BLOCK_LSB];

   // status write gating; refused while busy as well, since only polling is legal then
   assign status_wr = byte_done && (phase == sfsp_pkg::ph_data) && (opcode_o == sfsp_pkg::OP_STATUS_WRITE);
   assign status_wr_ok = status_wr && !busy_i && (wp_n_s || !lock);

   // protection bits, set at power-up to full protection and unlocked
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lock <= sfsp_pkg::RST_LOCK;
         level_hi <= sfsp_pkg::RST_LEVEL;
         level_lo <= sfsp_pkg::RST_LEVEL;
      end else if (status_wr_ok) begin
         lock <= rx_byte[sfsp_pkg::ST_LOCK];
         level_hi <= rx_byte[sfsp_pkg::ST_LEVEL_HI];
         level_lo <= rx_byte[sfsp_pkg::ST_LEVEL_LO];
      end
   end

   // status byte; reserved bits read zero
   always_comb begin
      status_o = 8'h00;
      status_o[sfsp_pkg::ST_BUSY] = busy_i;
      status_o[sfsp_pkg::ST_WRITE_ENABLE] = write_enable_latch_i;
      status_o[sfsp_pkg::ST_LEVEL_LO] = level_lo;
      status_o[sfsp_pkg::ST_LEVEL_HI] = level_hi;
      status_o[sfsp_pkg::ST_AAI] = aai_i;
      status_o[sfsp_pkg::ST_LOCK] = lock;
   end

   assign chip_erase_allowed_o = !level_hi && !level_lo;

   // outgoing byte: loaded one cycle after the byte edge so the array sees the new address
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_reg <= 8'h00;
         so_o <= 1'b0;
      end else if (load_pending) begin
         if (opcode_o == sfsp_pkg::OP_STATUS_READ) begin
            out_reg <= status_o;
         end else if (opcode_o == sfsp_pkg::OP_READ_ID) begin
            out_reg <= array_addr_o[0] ? sfsp_pkg::DEVICE_ID : sfsp_pkg::MAKER_ID;
         end else begin
            out_reg <= mem_rdata_i;
         end
      end else if (fall_ev && out_active) begin
         so_o <= out_reg[7];
         out_reg <= {out_reg[6:0], 1'b0};
      end
   end

   // release the output when deselected or paused
   assign so_oe_o = out_active && !cs_n_s && !hold_active;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_rise_counts;
      rise_ev && (bit_cnt != sfsp_pkg::LAST_BIT) |=> bit_cnt == $past(bit_cnt) + 3'h1;
   endproperty
   a_rise_counts: assert property (p_rise_counts) else $error("bit count did not follow clock rise");
   property p_so_on_fall;
      $changed(so_o) |-> $past(fall_ev);
   endproperty
   a_so_on_fall: assert property (p_so_on_fall) else $error("output bit changed off a falling edge");
   property p_hold_enter;
      !hold_active && !cs_n_s && !hold_n_s && !sck_s |=> hold_active;
   endproperty
   a_hold_enter: assert property (p_hold_enter) else $error("pause not entered");
   property p_hold_exit;
      hold_active && hold_n_s && !sck_s |=> !hold_active;
   endproperty
   a_hold_exit: assert property (p_hold_exit) else $error("pause not left");
   property p_hold_quiet;
      hold_active |-> (!so_oe_o && !rise_ev && !fall_ev) ##1 $stable(so_o);
   endproperty
   a_hold_quiet: assert property (p_hold_quiet) else $error("activity while paused");
   property p_hold_freeze;
      (hold_active && !cs_n_s)[*2] |-> $stable(bit_cnt) && $stable(out_reg);
   endproperty
   a_hold_freeze: assert property (p_hold_freeze) else $error("pause disturbed the sequence");
   property p_deselect;
      cs_n_s |=> (bit_cnt == 3'h0) && !so_oe_o && (phase == sfsp_pkg::ph_opcode);
   endproperty
   a_deselect: assert property (p_deselect) else $error("deselect did not reset interface");
   property p_hold_stays;
      cs_n_s && hold_active && !hold_n_s |=> hold_active;
   endproperty
   a_hold_stays: assert property (p_hold_stays) else $error("pause dropped on deselect");
   property p_locked;
      status_wr && lock && !wp_n_s |=> $stable({lock, level_hi, level_lo});
   endproperty
   a_locked: assert property (p_locked) else $error("locked status bits changed");
   property p_erase_gate;
      chip_erase_allowed_o == ({level_hi, level_lo} == 2'h0);
   endproperty
   a_erase_gate: assert property (p_erase_gate) else $error("chip erase gate wrong");
   property p_busy_bit;
      status_o[sfsp_pkg::ST_BUSY] == busy_i;
   endproperty
   a_busy_bit: assert property (p_busy_bit) else $error("busy bit wrong");

   c_hold: cover property (!hold_active ##1 hold_active ##[1:200] !hold_active);
   c_status_write: cover property (status_wr_ok);
   c_read_data: cover property (load_pending && opcode_o == sfsp_pkg::OP_READ);
   c_id_read: cover property (load_pending && opcode_o == sfsp_pkg::OP_READ_ID);
endmodule
`default_nettype wire

// ### sfsp_master.sv
`timescale 1ns/10ps
`default_nettype none
// behavioural bus master facing the serial port, 8 ref cycles per serial bit
module sfsp_master (
   input wire logic ref_clk_i,
   input wire logic so_i,
   input wire logic so_oe_i,
   output logic sck_o,
   output logic si_o,
   output logic cs_n_o,
   output logic hold_n_o,
   output logic [7:0] rx_byte_o,
   output logic rx_valid_o,
   output logic hold_oe_o
);
   logic last_so; // last level sampled
   logic mode3; // idle clock high in this frame
   logic so_w; // a released line shows the inverse, never a stale level
   assign so_w = so_oe_i ? so_i : ~last_so;
   // idle pins at time zero
   initial begin
      sck_o = 1'b0;
      si_o = 1'b0;
      cs_n_o = 1'b1;
      hold_n_o = 1'b1;
      rx_byte_o = 8'h00;
      rx_valid_o = 1'b0;
      hold_oe_o = 1'b0;
      last_so = 1'b0;
      mode3 = 1'b0;
   end
   task automatic wait_n(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   // clock parked at its idle level before select
   task automatic start(input logic m3);
      mode3 = m3;
      sck_o = m3;
      wait_n(4);
      cs_n_o = 1'b0;
      wait_n(4);
   endtask
   // mode 0 returns the clock low before deselect
   task automatic stop();
      if (!mode3) begin
         sck_o = 1'b0;
         wait_n(4);
      end
      cs_n_o = 1'b1;
      wait_n(6);
   endtask
   // pause with the clock low; pins wiggle meanwhile and must be ignored
   task automatic pause(input logic abort);
      hold_n_o = 1'b0;
      wait_n(4);
      repeat (2) begin
         hold_oe_o = hold_oe_o | so_oe_i;
         sck_o = ~sck_o;
         si_o = ~si_o;
         wait_n(4);
      end
      if (abort) begin
         cs_n_o = 1'b1;
      end
      wait_n(4);
      hold_oe_o = hold_oe_o | so_oe_i;
      hold_n_o = 1'b1;
      wait_n(4);
   endtask
   // one byte msb first, sampling the answer on each rise
   task automatic xbyte(input logic [7:0] tx, input int hold_bit, input logic abort, input logic chk);
      logic [7:0] rx;
      rx = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         sck_o = 1'b0;
         si_o = tx[i];
         wait_n(4);
         if (i == hold_bit) begin
            pause(abort);
            if (abort) begin
               return;
            end
         end
         sck_o = 1'b1;
         rx = {rx[6:0], so_w};
         last_so = so_w;
         wait_n(4);
      end
      if (chk) begin
         rx_byte_o = rx;
         rx_valid_o = 1'b1;
         wait_n(1);
         rx_valid_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic ref_clk_i, rst_n_i, wp_n, busy, wr_en, aai, so, so_oe, opv, blk, erase_ok, rx_valid, hold_oe;
   logic sck, si, cs_n, hold_n;
   logic [7:0] status, opcode, rx_byte, exp_q[$];
   logic [15:0] addr, array_addr;
   logic [3:0] sector;
   logic [31:0] seed = 32'hD00A;
   int fails = 0, cmp_count = 0, cycles = 0, opv_cnt = 0;
   sfsp_port sfsp_port_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .si_i(si), .cs_n_i(cs_n),
      .hold_n_i(hold_n), .wp_n_i(wp_n), .busy_i(busy), .write_enable_latch_i(wr_en), .aai_i(aai),
      .mem_rdata_i(array_addr[7:0] ^ 8'h3C), .so_o(so), .so_oe_o(so_oe), .status_o(status), .opcode_o(opcode),
      .opcode_valid_o(opv), .array_addr_o(array_addr), .sector_o(sector), .block_o(blk),
      .chip_erase_allowed_o(erase_ok));
   sfsp_master sfsp_master_inst (.ref_clk_i(ref_clk_i), .so_i(so), .so_oe_i(so_oe), .sck_o(sck), .si_o(si),
      .cs_n_o(cs_n), .hold_n_o(hold_n), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .hold_oe_o(hold_oe));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h00000000);
   endfunction
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (fails == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // status read with random flags, optional pause inside the second answer byte
   task automatic status_read(input logic m3, input int hb);
      seed = lfsr(seed);
      busy = seed[0];
      wr_en = seed[1];
      aai = seed[2];
      exp_q.push_back({1'b0, seed[2], 4'h3, seed[1], seed[0]});
      exp_q.push_back({1'b0, seed[2], 4'h3, seed[1], seed[0]});
      sfsp_master_inst.start(m3);
      sfsp_master_inst.xbyte(sfsp_pkg::OP_STATUS_READ, 8, 1'b0, 1'b0);
      sfsp_master_inst.xbyte(seed[15:8], 8, 1'b0, 1'b1);
      sfsp_master_inst.xbyte(seed[23:16], hb, 1'b0, 1'b1);
      sfsp_master_inst.stop();
      check("opcode", opcode, sfsp_pkg::OP_STATUS_READ);
   endtask
   task automatic wr_status(input logic [7:0] v);
      sfsp_master_inst.start(1'b0);
      sfsp_master_inst.xbyte(sfsp_pkg::OP_STATUS_WRITE, 8, 1'b0, 1'b0);
      sfsp_master_inst.xbyte(v, 8, 1'b0, 1'b0);
      sfsp_master_inst.stop();
   endtask
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   // answers off the queue, oldest first
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (opv === 1'b1) opv_cnt <= opv_cnt + 1;
      if (rx_valid === 1'b1) begin
         if (exp_q.size() == 0) check("rx_extra", 8'h01, 8'h00);
         else check("rx_byte", rx_byte, exp_q.pop_front());
      end
      if (cycles == 12000) begin
         fails++;
         end_of_test();
      end
   end
   initial begin
      rst_n_i = 1'b0;
      wp_n = 1'b1;
      busy = 1'b0;
      wr_en = 1'b0;
      aai = 1'b0;
      repeat (6) @(negedge ref_clk_i);
      check("status_rst", status, 8'h0C);
      check("erase_rst", {7'h00, erase_ok}, 8'h00);
      rst_n_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      status_read(1'b0, 3);
      status_read(1'b1, 5);
      check("hold_oe", {7'h00, hold_oe}, 8'h00);
      // lock while protect is low, then try to undo it
      busy = 1'b0;
      wp_n = 1'b0;
      wr_status(8'h80);
      check("st_lock", status & 8'h8C, 8'h80);
      check("erase_ok", {7'h00, erase_ok}, 8'h01);
      wr_status(8'h0C);
      check("st_locked", status & 8'h8C, 8'h80);
      wp_n = 1'b1;
      wr_status(8'h0C);
      check("st_unlock", status & 8'h8C, 8'h0C);
      // identification codes, clock idle high
      exp_q.push_back(sfsp_pkg::MAKER_ID);
      exp_q.push_back(sfsp_pkg::DEVICE_ID);
      sfsp_master_inst.start(1'b1);
      sfsp_master_inst.xbyte(sfsp_pkg::OP_READ_ID, 8, 1'b0, 1'b0);
      repeat (3) sfsp_master_inst.xbyte(8'h00, 8, 1'b0, 1'b0);
      repeat (2) sfsp_master_inst.xbyte(8'h00, 8, 1'b0, 1'b1);
      sfsp_master_inst.stop();
      // array read at a random address
      seed = lfsr(seed);
      addr = seed[15:0];
      sfsp_master_inst.start(1'b0);
      sfsp_master_inst.xbyte(sfsp_pkg::OP_READ, 8, 1'b0, 1'b0);
      sfsp_master_inst.xbyte(seed[23:16], 8, 1'b0, 1'b0);
      sfsp_master_inst.xbyte(addr[15:8], 8, 1'b0, 1'b0);
      sfsp_master_inst.xbyte(addr[7:0], 8, 1'b0, 1'b0);
      repeat (2) @(negedge ref_clk_i);
      check("addr_lo", array_addr[7:0], addr[7:0]);
      check("addr_hi", array_addr[15:8], addr[15:8]);
      check("sector", {4'h0, sector}, {4'h0, addr[15:12]});
      check("block", {7'h00, blk}, {7'h00, addr[15]});
      exp_q.push_back(addr[7:0] ^ 8'h3C);
      exp_q.push_back(8'(addr[7:0] + 8'h01) ^ 8'h3C);
      repeat (2) sfsp_master_inst.xbyte(8'h00, 8, 1'b0, 1'b1);
      sfsp_master_inst.stop();
      // deselect in mid pause, then a clean frame must count from zero
      sfsp_master_inst.start(1'b0);
      sfsp_master_inst.xbyte(sfsp_pkg::OP_READ_ID, 4, 1'b1, 1'b0);
      sfsp_master_inst.stop();
      check("oe_idle", {7'h00, so_oe}, 8'h00);
      check("hold_oe_end", {7'h00, hold_oe}, 8'h00);
      status_read(1'b0, 8);
      check("opcodes", 8'(opv_cnt), 8'h08);
      check("queue", 8'(exp_q.size()), 8'h00);
      end_of_test();
   end
endmodule
`default_nettype wire
